// ===== include/das_pkg.sv
// package for the dram access sequencer: constants, states, carriers
package das_pkg;
    localparam logic [2:0] SPACE_ONE    = 3'h1;
    localparam logic [2:0] SPACE_TWO    = 3'h2;
    localparam logic [2:0] SPACE_FOUR   = 3'h3;
    localparam logic [2:0] SPACE_CONT   = 3'h7;
    localparam int         SHIFT_BASE   = 8;
    localparam int         NUM_AREAS    = 4;
    localparam int         FIRST_AREA   = 2;

    typedef enum logic [2:0] {
        DAS_IDLE = 3'b000,
        DAS_PRE  = 3'b001,
        DAS_ROW  = 3'b010,
        DAS_HOLD = 3'b011,
        DAS_COL1 = 3'b100,
        DAS_WAIT = 3'b101,
        DAS_COL2 = 3'b110
    } das_state_e;

    // access request from the internal bus
    typedef struct packed {
        logic [23:0] addr;
        logic [1:0]  area;     // area index minus two
        logic        write;
        logic        word;
        logic [15:0] wdata;
    } das_req_s;

    // timing configuration
    typedef struct packed {
        logic [2:0] dram_space_select;
        logic [2:0] row_shift_select;
        logic [3:0] area_width_ctrl;
        logic [3:0] area_wait_enable;
        logic [2:0] wait_count_field;
        logic       pin_wait_enable;
        logic       column_length_bit;
        logic       row_timing_bit;
        logic [1:0] row_to_column_delay;
        logic [1:0] precharge_count;
        logic       oe_pin_enable;
    } das_cfg_s;
endpackage

// ===== design/das_sequencer.sv
// dram access sequencer: state machine and dram pin drive
`timescale 1ns/1ps
module das_sequencer (
    input  wire logic            ref_clk,
    input  wire logic            rstn,
    input  das_pkg::das_cfg_s    cfg,
    input  wire logic [3:0]      cs_dir_out,
    input  wire logic            req_valid,
    input  das_pkg::das_req_s    req,
    input  wire logic            refresh_req,
    output logic                 req_ready,
    output logic                 done,
    output logic [15:0]          rdata,
    output logic                 in_precharge,
    input  wire logic            wait_n,
    input  wire logic [15:0]     data_in,
    output logic [15:0]          data_out,
    output logic [15:0]          data_oe,
    output logic [15:0]          addr_out,
    output logic [3:0]           area_row_strobes_n,
    output logic [3:0]           area_row_strobes_oe,
    output logic                 upper_column_strobe_n,
    output logic                 lower_column_strobe_n,
    output logic                 high_byte_write_n,
    output logic                 read_strobe_n,
    output logic                 oe_pin_n
);
    das_pkg::das_state_e st_q, st_d;
    das_pkg::das_req_s   r_q;
    logic [2:0]  cnt_q, cnt_d;
    logic        wait_fall_q;
    logic        ras_mid_q;
    logic        refr_q;

    // area decode; continuous space folds everything onto area 2
    // space decode
    wire is_cont = cfg.dram_space_select == das_pkg::SPACE_CONT;
    wire [3:0] dram_areas =
        (cfg.dram_space_select == das_pkg::SPACE_ONE)  ? 4'h1 :
        (cfg.dram_space_select == das_pkg::SPACE_TWO)  ? 4'h3 :
        (cfg.dram_space_select == das_pkg::SPACE_FOUR) ? 4'hF :
        is_cont ? 4'hF : 4'h0;
    wire [1:0] eff_area = is_cont ? 2'h0 : r_q.area;
    wire [1:0] req_area = is_cont ? 2'h0 : req.area;
    wire       narrow   = cfg.area_width_ctrl[eff_area];
    wire       wait_en  = cfg.area_wait_enable[eff_area];
    wire       pin_en   = wait_en & cfg.pin_wait_enable;

    wire [4:0]  shamt   = 5'(das_pkg::SHIFT_BASE)
                        + {3'h0, cfg.row_shift_select[1:0]};
    wire [23:0] row_adr = r_q.addr >> shamt;
    wire        col_ph  = st_q == das_pkg::DAS_COL1
                       || st_q == das_pkg::DAS_WAIT
                       || st_q == das_pkg::DAS_COL2;

    // byte lanes: even address on upper lane, odd on lower; 8-bit space uses the upper lane only
    // two strobe bytes
    wire lane_up = narrow | r_q.word | ~r_q.addr[0];
    wire lane_lo = ~narrow & (r_q.word | r_q.addr[0]);

    // state sequencing
    // basic sequence
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            das_pkg::DAS_IDLE:
                if (req_valid && dram_areas[req_area])
                begin
                    st_d = das_pkg::DAS_PRE;
                    cnt_d = {1'b0, cfg.precharge_count};
                end
                else if (refresh_req)
                begin
                    st_d = das_pkg::DAS_PRE;
                    cnt_d = {1'b0, cfg.precharge_count};
                end
            das_pkg::DAS_PRE:
                if (cnt_q == 3'h0)
                    st_d = refr_q ? das_pkg::DAS_IDLE : das_pkg::DAS_ROW;
                else
                    cnt_d = cnt_q - 3'h1;
            das_pkg::DAS_ROW:
                if (cfg.row_to_column_delay != 2'h0)
                begin
                    st_d = das_pkg::DAS_HOLD;
                    cnt_d = {1'b0, cfg.row_to_column_delay} - 3'h1;
                end
                else
                    st_d = das_pkg::DAS_COL1;
            das_pkg::DAS_HOLD:
                if (cnt_q == 3'h0)
                    st_d = das_pkg::DAS_COL1;
                else
                    cnt_d = cnt_q - 3'h1;
            das_pkg::DAS_COL1:
            begin
                if (pin_en || (wait_en && cfg.wait_count_field != 3'h0))
                begin
                    st_d = das_pkg::DAS_WAIT;
                    cnt_d = (cfg.wait_count_field == 3'h0) ? 3'h0
                          : cfg.wait_count_field - 3'h1;
                end
                else
                    st_d = das_pkg::DAS_COL2;
                cnt_d = st_d == das_pkg::DAS_COL2
                      ? {2'h0, cfg.column_length_bit} : cnt_d;
            end
            das_pkg::DAS_WAIT:
                if (cnt_q != 3'h0)
                    cnt_d = cnt_q - 3'h1;
                else if (!(pin_en && wait_fall_q))
                begin
                    st_d = das_pkg::DAS_COL2;
                    cnt_d = {2'h0, cfg.column_length_bit};
                end
            das_pkg::DAS_COL2:
                if (cnt_q == 3'h0)
                    st_d = das_pkg::DAS_IDLE;
                else
                    cnt_d = cnt_q - 3'h1;
            default:
                st_d = das_pkg::DAS_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q  <= das_pkg::DAS_IDLE;
            cnt_q <= 3'h0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // request capture when leaving idle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            r_q    <= '0;
            refr_q <= 1'b0;
        end
        else if (st_q == das_pkg::DAS_IDLE && st_d == das_pkg::DAS_PRE)
        begin
            r_q    <= req;
            refr_q <= !(req_valid && dram_areas[req_area]);
        end
    end

    // falling-edge samples: wait pin and mid-state row strobe
    // mid state strobe
    always_ff @(negedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_fall_q <= 1'b0;
            ras_mid_q   <= 1'b0;
        end
        else
        begin
            wait_fall_q <= !wait_n;
            ras_mid_q   <= st_q == das_pkg::DAS_ROW;
        end
    end

    // read data captured at the end of the access
    // data lanes
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 16'h0000;
        else if (st_q == das_pkg::DAS_COL2 && cnt_q == 3'h0 && !r_q.write)
            rdata <= narrow ? {data_in[15:8], 8'h00} : data_in;
    end

    // row strobe: low from row state through last column state
    // early row strobe
    wire ras_act = !refr_q && (st_q == das_pkg::DAS_HOLD || col_ph
                 || (st_q == das_pkg::DAS_ROW
                     && (cfg.row_timing_bit || ras_mid_q)));
    // writes keep the column strobe up through waits so the data setup
    // before its fall grows with every wait; reads hold it low instead
    wire cas_act = st_q == das_pkg::DAS_COL2
                || (st_q == das_pkg::DAS_WAIT && !r_q.write);
    wire rd_act  = !r_q.write && !refr_q && st_q != das_pkg::DAS_IDLE
                && st_q != das_pkg::DAS_PRE;

    assign area_row_strobes_n = ~({3'h0, ras_act} << eff_area);
    assign area_row_strobes_oe = cs_dir_out;
    assign upper_column_strobe_n = !(cas_act && lane_up);
    assign lower_column_strobe_n = !(cas_act && lane_lo);
    assign high_byte_write_n     = !(col_ph && r_q.write && !refr_q);
    assign read_strobe_n = !rd_act;
    assign oe_pin_n      = !(rd_act && cfg.oe_pin_enable);
    assign addr_out      = col_ph ? r_q.addr[15:0] : row_adr[15:0];
    assign data_out      = narrow ? {r_q.wdata[15:8], 8'h00} : r_q.wdata;
    assign data_oe       = (r_q.write && col_ph && !refr_q)
                         ? (narrow ? 16'hFF00 : 16'hFFFF) : 16'h0000;
    assign req_ready     = st_q == das_pkg::DAS_IDLE;
    assign done = st_q == das_pkg::DAS_COL2 && cnt_q == 3'h0;
    assign in_precharge  = st_q == das_pkg::DAS_PRE;

    // assertions
    sequence s_row_then_hold;
        st_q == das_pkg::DAS_ROW ##1 st_q == das_pkg::DAS_HOLD;
    endsequence
    sequence s_two_waits;
        st_q == das_pkg::DAS_WAIT [*2] ##1 st_q == das_pkg::DAS_COL2;
    endsequence

    a_pre_to_row: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_PRE && cnt_q == 3'h0 && !refr_q
        |=> st_q == das_pkg::DAS_ROW)
        else $error("precharge did not lead to row state");
    a_row_order: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_ROW && cfg.row_to_column_delay == 2'h0
        |=> st_q == das_pkg::DAS_COL1)
        else $error("row state not followed by first column");
    a_hold_addr: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_row_then_hold |-> addr_out == $past(addr_out))
        else $error("row address lost in hold");
    a_col_addr: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        col_ph |-> addr_out == r_q.addr[15:0])
        else $error("column address shifted");
    a_narrow_lower: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        narrow |-> lower_column_strobe_n)
        else $error("lower strobe in 8-bit space");
    a_oe_only_read: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !oe_pin_n |-> !read_strobe_n && cfg.oe_pin_enable)
        else $error("dedicated oe without dram read");
    a_no_wait_off: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_COL1 && !wait_en
        |=> st_q == das_pkg::DAS_COL2)
        else $error("wait inserted while disabled");
    // judged on the falling edge so the first half of the row state is
    // seen; on the rising edge both timings already show the strobe low
    a_ras_early: assert property (
        @(negedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_ROW && cfg.row_timing_bit
        |-> area_row_strobes_n[eff_area] == 1'b0)
        else $error("row strobe late with row-timing bit set");
    a_ras_mid_high: assert property (
        @(negedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_ROW && !cfg.row_timing_bit
        |-> area_row_strobes_n[eff_area] == 1'b1)
        else $error("row strobe early with row-timing bit clear");
    a_ras_mid_low: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_ROW |-> area_row_strobes_n[eff_area] == 1'b0)
        else $error("row strobe not low by end of row state");
    a_write_cas: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_WAIT && r_q.write
        |-> upper_column_strobe_n && lower_column_strobe_n)
        else $error("column strobe fell before write waits ended");
    a_wait_count: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        st_q == das_pkg::DAS_COL1 && wait_en && !pin_en
        && cfg.wait_count_field == 3'h2 |=> s_two_waits)
        else $error("program wait count not kept");
    a_byte_lanes: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !upper_column_strobe_n && !lower_column_strobe_n
        |-> r_q.word && !narrow)
        else $error("both column strobes on a byte access");
    a_data_lanes: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        narrow |-> data_oe[7:0] == 8'h00)
        else $error("low data lane driven in 8-bit space");
    a_pre_len: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(in_precharge) && cfg.precharge_count == 2'h2
        |-> in_precharge [*3] ##1 !in_precharge)
        else $error("precharge length differs from count");
endmodule

// ===== sim/das_dram_model.sv
// dram partner model: read data per column strobe and the wait pin
`timescale 1ns/1ps
module das_dram_model (
    input  wire logic        ref_clk,
    input  wire logic        read_strobe_n,
    input  wire logic        upper_column_strobe_n,
    input  wire logic        lower_column_strobe_n,
    input  wire logic        hold_wait,
    output logic [15:0]      data_in,
    output logic             wait_n
);
    logic [15:0] junk_q = 16'h0F0F;
    // released lines toggle so stale data never looks valid
    always @(posedge ref_clk)
    begin
        junk_q <= ~junk_q;
    end
    // each byte driven only under its own strobe
    assign data_in[15:8] = (!read_strobe_n && !upper_column_strobe_n) ?
                           8'hA5 : junk_q[15:8];
    assign data_in[7:0]  = (!read_strobe_n && !lower_column_strobe_n) ?
                           8'h5A : junk_q[7:0];
    // pulled up, held low only while the bench asks
    assign wait_n = hold_wait ? 1'b0 : 1'b1;
endmodule

// ===== sim/test_dram_access_sequencer.sv
// self-checking bench for the dram access sequencer
`timescale 1ns/1ps
module test_dram_access_sequencer;
    logic ref_clk, rstn, req_valid, refresh_req, hold_wait;
    logic req_ready, done, in_precharge, wait_n;
    logic upper_column_strobe_n, lower_column_strobe_n;
    logic high_byte_write_n, read_strobe_n, oe_pin_n;
    logic [3:0]  cs_dir_out, area_row_strobes_n, area_row_strobes_oe;
    logic [15:0] rdata, data_in, data_out, data_oe, addr_out, row_a, col_a;
    logic [8:0]  seen;
    logic [15:0] oe_seen;
    das_pkg::das_cfg_s cfg;
    das_pkg::das_req_s req;
    int n_errors = 0;
    int total_checks = 0;
    int ncyc;

    das_sequencer DUT (.ref_clk, .rstn, .cfg, .cs_dir_out, .req_valid,
        .req, .refresh_req, .req_ready, .done, .rdata, .in_precharge,
        .wait_n, .data_in, .data_out, .data_oe, .addr_out,
        .area_row_strobes_n, .area_row_strobes_oe, .upper_column_strobe_n,
        .lower_column_strobe_n, .high_byte_write_n, .read_strobe_n,
        .oe_pin_n);
    das_dram_model PARTNER (.ref_clk, .read_strobe_n, .upper_column_strobe_n,
        .lower_column_strobe_n, .hold_wait, .data_in, .wait_n);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (exp !== got)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access; strobes seen low are gathered as ras,upper_column_strobe,lower_column_strobe,we,rd,oe
    task automatic acc(input logic [1:0] area, input logic [23:0] addr,
                       input logic wr, input logic wd);
        logic pre;
        pre = 1'b0;
        ncyc = 0;
        seen = '0;
        oe_seen = '0;
        @(negedge ref_clk);
        req = '{addr:addr, area:area, write:wr, word:wd, wdata:16'h3C96};
        req_valid = 1'b1;
        do
        begin
            @(negedge ref_clk);
            req_valid = 1'b0;
            ncyc++;
            if (pre && !in_precharge)
                row_a = addr_out;
            pre = in_precharge;
            oe_seen |= data_oe;
            seen |= ~{area_row_strobes_n, upper_column_strobe_n,
                      lower_column_strobe_n, high_byte_write_n,
                      read_strobe_n, oe_pin_n};
        end while (done !== 1'b1 && ncyc < 60);
        col_a = addr_out;
        chk("done", 16'h1, {15'h0, done});
        if (done !== 1'b1)
            tally_and_finish();
        // read data lands on the edge that closes the last column state
        @(negedge ref_clk);
    endtask

    task automatic run(input logic [1:0] ar, input logic [23:0] ad,
                       input logic wr, input logic wd,
                       input logic [8:0] es, input logic [15:0] ed);
        acc(ar, ad, wr, wd);
        chk("strobes", {7'h0, es}, {7'h0, seen});
        if (!wr)
            chk("rdata", ed, rdata);
        // every write here goes to 16-bit space
        if (wr)
        begin
            chk("data oe", 16'hFFFF, oe_seen);
            chk("data out", 16'h3C96, data_out);
        end
    endtask

    // a request outside dram space must never be answered
    task automatic refused(input logic [1:0] ar);
        @(negedge ref_clk);
        req.area = ar;
        req_valid = 1'b1;
        repeat (15) @(negedge ref_clk);
        chk("refused", 16'h1, {15'h0, req_ready & ~done});
        req_valid = 1'b0;
    endtask

    task automatic t_timing();
        int pc[4] = '{0, 3, 1, 2};
        int rc[4] = '{0, 3, 1, 2};
        int cl[4] = '{0, 1, 0, 1};
        int wt[4] = '{0, 7, 2, 5};
        int we[4] = '{0, 1, 1, 0};
        for (int i = 0; i < 4; i++)
        begin
            cfg.precharge_count = 2'(pc[i]);
            cfg.row_to_column_delay = 2'(rc[i]);
            cfg.column_length_bit = cl[i][0];
            cfg.wait_count_field = 3'(wt[i]);
            cfg.area_wait_enable = {3'h0, we[i][0]};
            cfg.row_shift_select = 3'(i);
            cfg.row_timing_bit = i[0];
            acc(2'h0, 24'hABCDEF, 1'b0, 1'b1);
            chk("cycles", 16'(4 + pc[i] + rc[i] + cl[i] + we[i] * wt[i]),
                16'(ncyc));
            chk("row addr", 16'(24'hABCDEF >> (8 + i)), row_a);
            chk("col addr", 16'hCDEF, col_a);
            chk("rdata", 16'hA55A, rdata);
        end
        cfg = '0;
        cfg.dram_space_select = 3'h1;
        $display("test timing done");
    endtask

    task automatic t_pins();
        cfg.dram_space_select = 3'h3;
        cfg.area_width_ctrl = 4'h4;
        cfg.oe_pin_enable = 1'b1;
        run(2'h1, 24'h000010, 1'b1, 1'b0, 9'h054, 16'h0);
        run(2'h1, 24'h000011, 1'b1, 1'b0, 9'h04C, 16'h0);
        run(2'h1, 24'h000012, 1'b0, 1'b1, 9'h05B, 16'hA55A);
        run(2'h2, 24'h000013, 1'b0, 1'b0, 9'h093, 16'hA500);
        run(2'h3, 24'h000014, 1'b1, 1'b1, 9'h11C, 16'h0);
        cfg.dram_space_select = 3'h2;
        run(2'h1, 24'h000016, 1'b0, 1'b1, 9'h05B, 16'hA55A);
        refused(2'h2);
        // reserved codes of space and shift never programmed
        cfg.dram_space_select = 3'h7;
        cfg.area_width_ctrl = 4'hE;
        run(2'h3, 24'h000018, 1'b0, 1'b1, 9'h03B, 16'hA55A);
        cfg.dram_space_select = 3'h1;
        refused(2'h1);
        cfg = '0;
        cfg.dram_space_select = 3'h1;
        $display("test pins done");
    endtask

    task automatic t_wait();
        cfg.pin_wait_enable = 1'b1;
        hold_wait = 1'b1;
        acc(2'h0, 24'h000020, 1'b0, 1'b1);
        chk("no wait", 16'h4, 16'(ncyc));
        cfg.area_wait_enable = 4'h1;
        hold_wait = 1'b0;
        acc(2'h0, 24'h000022, 1'b0, 1'b1);
        chk("one wait", 16'h5, 16'(ncyc));
        hold_wait = 1'b1;
        fork
            acc(2'h0, 24'h000024, 1'b0, 1'b1);
            begin
                repeat (20) @(negedge ref_clk);
                // released off the falling edge at which the pin is sampled
                @(posedge ref_clk);
                hold_wait = 1'b0;
            end
        join
        chk("stretch", 16'h1, {15'h0, ncyc > 20 && ncyc < 26});
        chk("rdata", 16'hA55A, rdata);
        run(2'h0, 24'h000026, 1'b1, 1'b1, 9'h03C, 16'h0);
        chk("write wait", 16'h5, 16'(ncyc));
        cfg.pin_wait_enable = 1'b0;
        cfg.area_wait_enable = 4'h0;
        $display("test wait done");
    endtask

    task automatic t_refresh();
        cfg.precharge_count = 2'h2;
        ncyc = 0;
        @(negedge ref_clk);
        refresh_req = 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge ref_clk);
            if (in_precharge === 1'b1)
            begin
                refresh_req = 1'b0;
                ncyc++;
            end
        end
        chk("refresh pre", 16'h3, 16'(ncyc));
        cfg.precharge_count = 2'h0;
        $display("test refresh done");
    endtask

    initial
    begin
        rstn = 1'b0;
        req_valid = 1'b0;
        refresh_req = 1'b0;
        hold_wait = 1'b0;
        cs_dir_out = 4'h0;
        req = '0;
        cfg = '0;
        cfg.dram_space_select = 3'h1;
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        chk("pin dir", 16'h0, {12'h0, area_row_strobes_oe});
        cs_dir_out = 4'hF;
        @(negedge ref_clk);
        chk("pin dir", 16'hF, {12'h0, area_row_strobes_oe});
        t_timing();
        t_pins();
        t_wait();
        t_refresh();
        tally_and_finish();
    end
endmodule
